// [hdl/sspric_defs.vh]
// Register map, field positions, reset values and source codes of the status select block.
// Assumes nothing; definitions only.
`ifndef SSPRIC_DEFS_VH
`define SSPRIC_DEFS_VH

// Register indices and byte addresses
`define SSPRIC_IDX_STAT2 8'h1c
`define SSPRIC_IDX_REFCTL 8'h1d
`define SSPRIC_ADDR_STAT2 12'h070
`define SSPRIC_ADDR_REFCTL 12'h074
`define SSPRIC_ADDR_INT_STATUS 12'h080
`define SSPRIC_ADDR_INT_ENABLE 12'h084
`define SSPRIC_ADDR_INT_CLEAR 12'h088
`define SSPRIC_ADDR_TEST_CTL 12'h08c
`define SSPRIC_ADDR_LIVE 12'h090

// Field positions
`define SSPRIC_SEL_HI 7
`define SSPRIC_SEL_LO 4
`define SSPRIC_POL_BIT 3
`define SSPRIC_BYP_BIT 7

// Reset values and write masks
`define SSPRIC_STAT2_RESET 8'h28
`define SSPRIC_REFCTL_RESET 8'h06
`define SSPRIC_REFCTL_WMASK 8'hbf
`define SSPRIC_STAT2_WMASK 8'hf8

// Source codes
`define SSPRIC_SRC_LOS_PRI 4'h0
`define SSPRIC_SRC_LOS_SEC 4'h1
`define SSPRIC_SRC_LOL1 4'h2
`define SSPRIC_SRC_RDIV1 4'h3
`define SSPRIC_SRC_NDIV1 4'h4
`define SSPRIC_SRC_LOL2 4'h5
`define SSPRIC_SRC_RDIV2 4'h6
`define SSPRIC_SRC_NDIV2 4'h7
`define SSPRIC_SRC_CAL1 4'h8
`define SSPRIC_SRC_CAL2 4'h9
`define SSPRIC_SRC_COMBINED_INTERRUPT_INDICATION 4'ha
`define SSPRIC_SRC_MDIV1 4'hb
`define SSPRIC_SRC_MDIV2 4'hc
`define SSPRIC_SRC_NVM 4'hd
`define SSPRIC_SRC_SW1 4'he
`define SSPRIC_SRC_SW2 4'hf

// AXI responses and event count
`define SSPRIC_RESP_OKAY 2'b00
`define SSPRIC_RESP_SLVERR 2'b10
`define SSPRIC_NUM_EVT 6

`endif

// [hdl/sspric_top.v]
// Status pin source select and reference input configuration with an AXI4-Lite slave.
// Assumes indicator inputs are asynchronous to core_clk; divider inputs are already divided by two.
// Operation
// - Four-bit source select in bits 7:4, reset 0x2 selects first PLL lock loss.
// - Codes 0x0 and 0x1 route primary and secondary loss of signal.
// - Codes 0x2 and 0x5 route first and second PLL loss of lock.
// - Codes 0x3 and 0x6 route R divider halves, valid when R not bypassed.
// - Codes 0x4 and 0x7 route N divider outputs divided by two.
// - Codes 0xB and 0xC route M divider halves, valid when M not bypassed.
// - Codes 0x8 and 0x9 show VCO calibration in progress per PLL.
// - Codes 0xE and 0xF show secondary to primary switchback per PLL.
// - Polarity bit 3, reset one, selects active high; cleared means active low.
// - Active test configuration overrides source and polarity on the pin.
// - Detector bypass bit 7 makes state machines treat both inputs valid.
// - Bypass leaves interrupt flags and status pin on real detector results.
// - Bit 5, reset zero, enables secondary 50 ohm termination to ground.
// - Bit 4, reset zero, enables primary 50 ohm termination to ground.
// - Bit 3, reset zero, enables secondary 100 ohm differential termination.
// - Bit 2, reset one, enables primary 100 ohm differential termination.
// - Bit 1, reset one, enables secondary AC coupling input bias.
// - Bit 0, reset zero, enables primary AC coupling input bias.
`timescale 1ns/1ps
`default_nettype none
`include "sspric_defs.vh"

module sspric_top (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,
	// AXI4-Lite write address
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Indicators from the clock core, asynchronous
	input wire primary_loss_of_signal_flag,
	input wire secondary_loss_of_signal_flag,
	input wire pll1_loss_of_lock_flag,
	input wire pll2_loss_of_lock_flag,
	input wire pll1_vco_cal_active,
	input wire pll2_vco_cal_active,
	input wire pll1_switchback,
	input wire pll2_switchback,
	input wire nvm_busy,
	// Divider outputs already divided by two, and bypass states
	input wire pll1_r_div_half,
	input wire pll2_r_div_half,
	input wire pll1_n_div_half,
	input wire pll2_n_div_half,
	input wire pll1_m_div_half,
	input wire pll2_m_div_half,
	input wire pll1_r_bypassed,
	input wire pll2_r_bypassed,
	input wire pll1_m_bypassed,
	input wire pll2_m_bypassed,
	// Pin and analog controls
	output reg second_status_pin,
	output reg primary_input_valid,
	output reg secondary_input_valid,
	output reg secondary_ground_termination_enable,
	output reg primary_ground_termination_enable,
	output reg secondary_diff_termination_enable,
	output reg primary_diff_termination_enable,
	output reg secondary_ac_bias_enable,
	output reg primary_ac_bias_enable,
	output reg combined_interrupt_indication
);

////////////////////////////////////////////////////////////////////////////////
// Reset release

reg [1:0] rst_sync;
wire rst_core_n = rst_sync[1];

always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		rst_sync <= 2'b00;
	end else begin
		rst_sync <= {rst_sync[0], 1'b1};
	end
end

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers: three stages, change taken when stages two and three agree

localparam NIN = 19;
wire [NIN-1:0] raw_in = {pll2_m_bypassed, pll1_m_bypassed, pll2_r_bypassed, pll1_r_bypassed,
	pll2_m_div_half, pll1_m_div_half, pll2_n_div_half, pll1_n_div_half,
	pll2_r_div_half, pll1_r_div_half, nvm_busy, pll2_switchback, pll1_switchback,
	pll2_vco_cal_active, pll1_vco_cal_active, pll2_loss_of_lock_flag,
	pll1_loss_of_lock_flag, secondary_loss_of_signal_flag, primary_loss_of_signal_flag};
reg [NIN-1:0] sync1;
reg [NIN-1:0] sync2;
reg [NIN-1:0] sync3;
reg [NIN-1:0] clean;

genvar gi;
generate
	for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
		always @(posedge core_clk or negedge rst_core_n) begin
			if (!rst_core_n) begin
				sync1[gi] <= 1'b0;
				sync2[gi] <= 1'b0;
				sync3[gi] <= 1'b0;
				clean[gi] <= 1'b0;
			end else begin
				sync1[gi] <= raw_in[gi];
				sync2[gi] <= sync1[gi];
				sync3[gi] <= sync2[gi];
				if (sync2[gi] == sync3[gi]) begin
					clean[gi] <= sync3[gi];
				end
			end
		end
	end
endgenerate

wire los_pri = clean[0];
wire los_sec = clean[1];
wire lol1 = clean[2];
wire lol2 = clean[3];
wire cal1 = clean[4];
wire cal2 = clean[5];
wire sw1 = clean[6];
wire sw2 = clean[7];
wire nvm = clean[8];
wire rdiv1 = clean[9];
wire rdiv2 = clean[10];
wire ndiv1 = clean[11];
wire ndiv2 = clean[12];
wire mdiv1 = clean[13];
wire mdiv2 = clean[14];
wire rbyp1 = clean[15];
wire rbyp2 = clean[16];
wire mbyp1 = clean[17];
wire mbyp2 = clean[18];

////////////////////////////////////////////////////////////////////////////////
// Registers

reg [7:0] stat2_cfg;
reg [7:0] ref_ctl;
reg [5:0] int_status;
reg [5:0] int_enable;
reg [2:0] test_ctl;
reg [5:0] evt_prev;

// Events: rising edges of the real detector, lock and switchback results
wire [5:0] evt_level = {sw2, sw1, lol2, lol1, los_sec, los_pri};
wire [5:0] evt_pulse = evt_level & ~evt_prev;

// Write handshake: address and data taken in either order
reg aw_held;
reg w_held;
reg [11:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
wire wr_go = aw_held && w_held && !s_axi_bvalid;
wire wr_lane0 = wr_go && w_strb[0];
wire [5:0] int_clear = (wr_lane0 && aw_addr == `SSPRIC_ADDR_INT_CLEAR) ? w_data[5:0] : 6'h00;
wire wr_known = (aw_addr == `SSPRIC_ADDR_STAT2) || (aw_addr == `SSPRIC_ADDR_REFCTL) ||
	(aw_addr == `SSPRIC_ADDR_INT_ENABLE) || (aw_addr == `SSPRIC_ADDR_INT_CLEAR) ||
	(aw_addr == `SSPRIC_ADDR_TEST_CTL);

always @(posedge core_clk or negedge rst_core_n) begin
	if (!rst_core_n) begin
		aw_held <= 1'b0;
		w_held <= 1'b0;
		aw_addr <= 12'h000;
		w_data <= 32'h00000000;
		w_strb <= 4'h0;
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `SSPRIC_RESP_OKAY;
		stat2_cfg <= `SSPRIC_STAT2_RESET;
		ref_ctl <= `SSPRIC_REFCTL_RESET;
		int_status <= 6'h00;
		int_enable <= 6'h00;
		test_ctl <= 3'h0;
		evt_prev <= 6'h00;
	end else begin
		evt_prev <= evt_level;
		// Set wins over a clear in the same cycle
		int_status <= (int_status & ~int_clear) | evt_pulse;
		s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
		s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		if (wr_go) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_known ? `SSPRIC_RESP_OKAY : `SSPRIC_RESP_SLVERR;
			if (wr_lane0) begin
				case (aw_addr)
					`SSPRIC_ADDR_STAT2: begin
						stat2_cfg <= w_data[7:0] & `SSPRIC_STAT2_WMASK;
					end
					`SSPRIC_ADDR_REFCTL: begin
						ref_ctl <= w_data[7:0] & `SSPRIC_REFCTL_WMASK;
					end
					`SSPRIC_ADDR_INT_ENABLE: begin
						int_enable <= w_data[5:0];
					end
					`SSPRIC_ADDR_TEST_CTL: begin
						test_ctl <= w_data[2:0];
					end
					default: begin
					end
				endcase
			end
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read channel: one cycle from address taken to data valid

reg [31:0] rd_word;
reg rd_known;

always @* begin
	rd_word = 32'h00000000;
	rd_known = 1'b1;
	case (s_axi_araddr)
		`SSPRIC_ADDR_STAT2: rd_word[7:0] = stat2_cfg;
		`SSPRIC_ADDR_REFCTL: rd_word[7:0] = ref_ctl;
		`SSPRIC_ADDR_INT_STATUS: rd_word[5:0] = int_status;
		`SSPRIC_ADDR_INT_ENABLE: rd_word[5:0] = int_enable;
		`SSPRIC_ADDR_INT_CLEAR: rd_word = 32'h00000000;
		`SSPRIC_ADDR_TEST_CTL: rd_word[2:0] = test_ctl;
		`SSPRIC_ADDR_LIVE: rd_word[8:0] = {nvm, sw2, sw1, cal2, cal1, lol2, lol1, los_sec, los_pri};
		default: rd_known = 1'b0;
	endcase
end

always @(posedge core_clk or negedge rst_core_n) begin
	if (!rst_core_n) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `SSPRIC_RESP_OKAY;
	end else begin
		s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_known ? `SSPRIC_RESP_OKAY : `SSPRIC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Status pin source mux, polarity, test override

wire [3:0] src_sel = stat2_cfg[`SSPRIC_SEL_HI:`SSPRIC_SEL_LO];
wire any_int = |(int_status & int_enable);
reg src_bit;

always @* begin
	case (src_sel)
		`SSPRIC_SRC_LOS_PRI: begin
			src_bit = los_pri;
		end
		`SSPRIC_SRC_LOS_SEC: begin
			src_bit = los_sec;
		end
		`SSPRIC_SRC_LOL1: begin
			src_bit = lol1;
		end
		`SSPRIC_SRC_LOL2: begin
			src_bit = lol2;
		end
		// Undefined while bypassed, so held low rather than passing junk
		`SSPRIC_SRC_RDIV1: begin
			src_bit = rdiv1 & ~rbyp1;
		end
		`SSPRIC_SRC_RDIV2: begin
			src_bit = rdiv2 & ~rbyp2;
		end
		`SSPRIC_SRC_NDIV1: begin
			src_bit = ndiv1;
		end
		`SSPRIC_SRC_NDIV2: begin
			src_bit = ndiv2;
		end
		`SSPRIC_SRC_MDIV1: begin
			src_bit = mdiv1 & ~mbyp1;
		end
		`SSPRIC_SRC_MDIV2: begin
			src_bit = mdiv2 & ~mbyp2;
		end
		`SSPRIC_SRC_CAL1: begin
			src_bit = cal1;
		end
		`SSPRIC_SRC_CAL2: begin
			src_bit = cal2;
		end
		`SSPRIC_SRC_SW1: begin
			src_bit = sw1;
		end
		`SSPRIC_SRC_SW2: begin
			src_bit = sw2;
		end
		`SSPRIC_SRC_COMBINED_INTERRUPT_INDICATION: begin
			src_bit = any_int;
		end
		`SSPRIC_SRC_NVM: begin
			src_bit = nvm;
		end
		default: begin
			src_bit = 1'b0;
		end
	endcase
end

// Test bit 2 enables override; bit 0 is the forced level
wire pin_next = test_ctl[2] ? test_ctl[0] :
	(stat2_cfg[`SSPRIC_POL_BIT] ? src_bit : ~src_bit);

always @(posedge core_clk or negedge rst_core_n) begin
	if (!rst_core_n) begin
		second_status_pin <= 1'b0;
		primary_input_valid <= 1'b0;
		secondary_input_valid <= 1'b0;
		secondary_ground_termination_enable <= 1'b0;
		primary_ground_termination_enable <= 1'b0;
		secondary_diff_termination_enable <= 1'b0;
		primary_diff_termination_enable <= 1'b1;
		secondary_ac_bias_enable <= 1'b1;
		primary_ac_bias_enable <= 1'b0;
		combined_interrupt_indication <= 1'b0;
	end else begin
		second_status_pin <= pin_next;
		// Bypass reaches only the state machine view, not flags or pin
		primary_input_valid <= ref_ctl[`SSPRIC_BYP_BIT] | ~los_pri;
		secondary_input_valid <= ref_ctl[`SSPRIC_BYP_BIT] | ~los_sec;
		secondary_ground_termination_enable <= ref_ctl[5];
		primary_ground_termination_enable <= ref_ctl[4];
		secondary_diff_termination_enable <= ref_ctl[3];
		primary_diff_termination_enable <= ref_ctl[2];
		secondary_ac_bias_enable <= ref_ctl[1];
		primary_ac_bias_enable <= ref_ctl[0];
		combined_interrupt_indication <= any_int;
	end
end

endmodule // sspric_top

`default_nettype wire

// [bench/sspric_top_properties.sv]
// Port-level checker for the status select and reference input block.
// Assumes single core_clk domain and rst_n active low; bound onto every sspric_top.
`timescale 1ns/1ps
`default_nettype none
`include "sspric_defs.vh"

module sspric_checker (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Bus handshakes
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Detectors and outputs
	input wire logic primary_loss_of_signal_flag,
	input wire logic secondary_loss_of_signal_flag,
	input wire logic primary_input_valid,
	input wire logic secondary_input_valid,
	input wire logic secondary_ground_termination_enable,
	input wire logic primary_ground_termination_enable,
	input wire logic secondary_diff_termination_enable,
	input wire logic primary_diff_termination_enable,
	input wire logic secondary_ac_bias_enable,
	input wire logic primary_ac_bias_enable,
	input wire logic combined_interrupt_indication,
	input wire logic second_status_pin
);
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic [3:0] plo;
	logic [3:0] slo;
	wire [5:0] terms = {secondary_ground_termination_enable, primary_ground_termination_enable,
		secondary_diff_termination_enable, primary_diff_termination_enable,
		secondary_ac_bias_enable, primary_ac_bias_enable};

	////////////////////////////////////////////////////////////////
	// Quiet-detector counters; long enough to cover sync and reset release
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			plo <= 4'h0;
			slo <= 4'h0;
		end else begin
			plo <= primary_loss_of_signal_flag ? 4'h0 : (plo == 4'hf ? plo : plo + 4'h1);
			slo <= secondary_loss_of_signal_flag ? 4'h0 : (slo == 4'hf ? slo : slo + 4'h1);
		end
	end

	////////////////////////////////////////////////////////////////
	property p_reset_terms;
		disable iff (1'b0) (!rst_n ##1 !rst_n) |-> terms == 6'h06;
	endproperty
	a_reset_terms: assert property (p_reset_terms) else $error("termination reset levels wrong");
	property p_terms_by_write;
		$changed(terms) |-> s_axi_bvalid || $past(s_axi_bvalid);
	endproperty
	a_terms_by_write: assert property (p_terms_by_write) else $error("termination changed without write");
	property p_pri_valid;
		plo == 4'hf |-> primary_input_valid;
	endproperty
	a_pri_valid: assert property (p_pri_valid) else $error("primary input not valid");
	property p_sec_valid;
		slo == 4'hf |-> secondary_input_valid;
	endproperty
	a_sec_valid: assert property (p_sec_valid) else $error("secondary input not valid");
	property p_bresp_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
	property p_rdata_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped");
	property p_slverr_zero;
		s_axi_rvalid && s_axi_rresp == `SSPRIC_RESP_SLVERR |-> s_axi_rdata == 32'h0;
	endproperty
	a_slverr_zero: assert property (p_slverr_zero) else $error("refused read returned data");
	property p_aw_pulse;
		s_axi_awready |=> !s_axi_awready;
	endproperty
	a_aw_pulse: assert property (p_aw_pulse) else $error("address ready held");
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `SSPRIC_RESP_SLVERR);
	c_irq: cover property (combined_interrupt_indication);
	c_pin: cover property ($rose(second_status_pin));
endmodule // sspric_checker

bind sspric_top sspric_checker i_sspric_checker (.*);
`default_nettype wire

// [bench/sspric_top_bench.sv]
// Self-checking bench for sspric_top driven over AXI4-Lite.
// Assumes the checker file is compiled alongside and the defs header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "sspric_defs.vh"

module sspric_top_bench;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic second_status_pin, primary_input_valid, secondary_input_valid, combined_interrupt_indication;
	logic secondary_ground_termination_enable, primary_ground_termination_enable, secondary_diff_termination_enable;
	logic primary_diff_termination_enable, secondary_ac_bias_enable, primary_ac_bias_enable;
	logic [15:0] ind = 16'h0;
	logic [3:0] byp = 4'h0;
	int errors = 0, compares = 0, cycles = 0, c;
	wire [5:0] terms = {secondary_ground_termination_enable, primary_ground_termination_enable,
		secondary_diff_termination_enable, primary_diff_termination_enable,
		secondary_ac_bias_enable, primary_ac_bias_enable};

	sspric_top i_sspric_top (.*, .primary_loss_of_signal_flag(ind[0]), .secondary_loss_of_signal_flag(ind[1]),
		.pll1_loss_of_lock_flag(ind[2]), .pll1_r_div_half(ind[3]), .pll1_n_div_half(ind[4]),
		.pll2_loss_of_lock_flag(ind[5]), .pll2_r_div_half(ind[6]), .pll2_n_div_half(ind[7]),
		.pll1_vco_cal_active(ind[8]), .pll2_vco_cal_active(ind[9]), .pll1_m_div_half(ind[11]),
		.pll2_m_div_half(ind[12]), .nvm_busy(ind[13]), .pll1_switchback(ind[14]), .pll2_switchback(ind[15]),
		.pll1_r_bypassed(byp[0]), .pll2_r_bypassed(byp[1]), .pll1_m_bypassed(byp[2]), .pll2_m_bypassed(byp[3]));

	////////////////////////////////////////////////////////////////
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			results;
		end
	end

	////////////////////////////////////////////////////////////////
	task results;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task chk_word(input [31:0] g, input [31:0] e);
		compares = compares + 1;
		if (g !== e) begin
			errors = errors + 1;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task chk_resp(input [1:0] g, input [1:0] e);
		chk_word({30'h0, g}, {30'h0, e});
	endtask
	task settle;
		repeat (8) @(posedge core_clk);
	endtask
	// Ready raised only after valid seen, so each response is stalled once
	task wr(input [11:0] a, input [31:0] d, input [1:0] er);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready));
		s_axi_bready <= 1'b0;
		chk_resp(s_axi_bresp, er);
	endtask
	task rd(input [11:0] a, input [31:0] e, input [1:0] er);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready));
		s_axi_rready <= 1'b0;
		chk_resp(s_axi_rresp, er);
		chk_word(s_axi_rdata, e);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd(`SSPRIC_ADDR_STAT2, 32'h28, `SSPRIC_RESP_OKAY);
		rd(`SSPRIC_ADDR_REFCTL, 32'h06, `SSPRIC_RESP_OKAY);
		chk_word(terms, 32'h06);
		$display("test reset done");
		wr(`SSPRIC_ADDR_REFCTL, 32'hff, `SSPRIC_RESP_OKAY);
		rd(`SSPRIC_ADDR_REFCTL, 32'hbf, `SSPRIC_RESP_OKAY);
		for (c = 0; c < 6; c++) begin
			wr(`SSPRIC_ADDR_REFCTL, 32'h1 << c, `SSPRIC_RESP_OKAY);
			settle;
			chk_word(terms, 32'h1 << c);
		end
		wr(`SSPRIC_ADDR_STAT2, 32'hff, `SSPRIC_RESP_OKAY);
		rd(`SSPRIC_ADDR_STAT2, 32'hf8, `SSPRIC_RESP_OKAY);
		s_axi_wstrb <= 4'he;
		wr(`SSPRIC_ADDR_REFCTL, 32'h3f, `SSPRIC_RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rd(`SSPRIC_ADDR_REFCTL, 32'h20, `SSPRIC_RESP_OKAY);
		wr(12'h100, 32'h5a, `SSPRIC_RESP_SLVERR);
		rd(12'h100, 32'h0, `SSPRIC_RESP_SLVERR);
		$display("test registers done");
		for (c = 0; c < 32; c++) begin
			if (c[3:0] != 4'ha) begin
				wr(`SSPRIC_ADDR_STAT2, {24'h0, c[3:0], !c[4], 3'h0}, `SSPRIC_RESP_OKAY);
				ind <= 16'h1 << c[3:0];
				settle;
				chk_word(second_status_pin, !c[4]);
				ind <= ~(16'h1 << c[3:0]);
				settle;
				chk_word(second_status_pin, c[4]);
			end
		end
		byp <= 4'hf;
		wr(`SSPRIC_ADDR_STAT2, 32'h38, `SSPRIC_RESP_OKAY);
		ind <= 16'h0008;
		settle;
		chk_word(second_status_pin, 32'h0);
		wr(`SSPRIC_ADDR_STAT2, 32'hb8, `SSPRIC_RESP_OKAY);
		ind <= 16'h0800;
		settle;
		chk_word(second_status_pin, 32'h0);
		byp <= 4'h0;
		$display("test routing done");
		wr(`SSPRIC_ADDR_REFCTL, 32'h80, `SSPRIC_RESP_OKAY);
		wr(`SSPRIC_ADDR_STAT2, 32'h08, `SSPRIC_RESP_OKAY);
		ind <= 16'h0003;
		settle;
		chk_word({primary_input_valid, secondary_input_valid}, 32'h3);
		chk_word(second_status_pin, 32'h1);
		rd(`SSPRIC_ADDR_LIVE, 32'h3, `SSPRIC_RESP_OKAY);
		wr(`SSPRIC_ADDR_REFCTL, 32'h00, `SSPRIC_RESP_OKAY);
		settle;
		chk_word({primary_input_valid, secondary_input_valid}, 32'h0);
		$display("test bypass done");
		ind <= 16'h0;
		wr(`SSPRIC_ADDR_INT_CLEAR, 32'h3f, `SSPRIC_RESP_OKAY);
		rd(`SSPRIC_ADDR_INT_STATUS, 32'h0, `SSPRIC_RESP_OKAY);
		wr(`SSPRIC_ADDR_INT_ENABLE, 32'h1, `SSPRIC_RESP_OKAY);
		wr(`SSPRIC_ADDR_STAT2, 32'ha8, `SSPRIC_RESP_OKAY);
		ind <= 16'h1;
		settle;
		chk_word(combined_interrupt_indication, 32'h1);
		chk_word(second_status_pin, 32'h1);
		rd(`SSPRIC_ADDR_INT_STATUS, 32'h1, `SSPRIC_RESP_OKAY);
		wr(`SSPRIC_ADDR_TEST_CTL, 32'h4, `SSPRIC_RESP_OKAY);
		settle;
		chk_word(second_status_pin, 32'h0);
		wr(`SSPRIC_ADDR_STAT2, 32'ha0, `SSPRIC_RESP_OKAY);
		wr(`SSPRIC_ADDR_TEST_CTL, 32'h5, `SSPRIC_RESP_OKAY);
		settle;
		chk_word(second_status_pin, 32'h1);
		wr(`SSPRIC_ADDR_TEST_CTL, 32'h0, `SSPRIC_RESP_OKAY);
		wr(`SSPRIC_ADDR_INT_ENABLE, 32'h0, `SSPRIC_RESP_OKAY);
		settle;
		chk_word(combined_interrupt_indication, 32'h0);
		wr(`SSPRIC_ADDR_INT_ENABLE, 32'h1, `SSPRIC_RESP_OKAY);
		ind <= 16'h0;
		wr(`SSPRIC_ADDR_INT_CLEAR, 32'h1, `SSPRIC_RESP_OKAY);
		settle;
		chk_word(combined_interrupt_indication, 32'h0);
		rd(`SSPRIC_ADDR_INT_STATUS, 32'h0, `SSPRIC_RESP_OKAY);
		$display("test interrupt done");
		results;
	end
endmodule // sspric_top_bench
`default_nettype wire
